/* design/dac_port_defs.vh */
// Offsets, field positions, reset values and timing counts of the DAC digital port
`ifndef DAC_PORT_DEFS_VH
`define DAC_PORT_DEFS_VH

// Register offsets
`define SERIAL_PORT_CONFIG_ADDR 5'h00
`define DATA_CLOCK_CONFIG_ADDR  5'h02
`define REG_COUNT               8

// serial_port_config fields
`define SPC_SDIO_OUTPUT_BIT 7
`define SPC_SDO_RATE_BIT    6
`define SPC_SOFT_RESET_BIT  5

// data_clock_config fields
`define DCC_LOCK_AS_CLK_BIT 3
`define DCC_CLK_INPUT_BIT   2
`define DCC_PLL_ENABLE_BIT  1
`define DCC_ONE_PORT_BIT    0

// Reset values
`define REG_RESET_VALUE 8'h00

// Serial instruction: bit 7 read, bits 4:0 address
`define INSTR_READ_BIT  7
`define INSTR_ADDR_MSB  4
`define INSTR_BITS      5'h08
`define FRAME_BITS      5'h10

// Timing
`define SYS_CLK_PERIOD_NS 100
`define SYNC_STAGES       2

`endif

/* design/dac_port.v */
// Serial control port, sample capture and clock outputs of the dual DAC
`timescale 1ns/1ps
`include "dac_port_defs.vh"

module sample_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;

	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // sample_fifo

// How it works
// RULE1 - PLL enabled: lock pin high when locked, low when not locked.
// RULE2 - Bit 3 of register 02h turns lock pin into data clock in/out.
// RULE3 - Single-port: select line 1 at sample clock rise captures into I.
// RULE4 - Single-port: select line 0 at capture edge places data into Q.
// RULE5 - Two-port: select line pin is second port's most significant bit.
// RULE6 - PLL off, single-port: bit-14 pin outputs clock at twice channel rate.
// RULE7 - Separate out line drives read data unless bidirectional line is output.
// RULE8 - Separate out line may instead carry the data rate clock.
// RULE9 - Bit 7 of register 00h sets data line direction; resets to input.
// RULE10 - Serial input bits are sampled on serial clock rising edge.
// RULE11 - Serial output bits are launched on serial clock falling edge.
// RULE12 - High chip select resets serial logic and starts a new instruction.
// RULE13 - Hardware reset pin high returns every register to default.
// RULE14 - Writing 1 to bit 5 of register 00h does a software reset.
// RULE15 - Software reset keeps register 00h, defaults all other registers.
// RULE16 - Host holds chip select low through the whole instruction.
// RULE17 - Source alternates I and Q samples using the doubled-rate clock.
module dac_port #(
	parameter DATA_W     = 16,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW    = 2
) (
	// Clock and reset
	input  wire              clk,
	input  wire              rst,
	// Hardware reset pin
	input  wire              reset_pin,
	// Serial control port
	input  wire              serial_clock,
	input  wire              serial_chip_select,
	input  wire              sdio_in,
	output reg               sdio_out_q,
	output reg               sdio_oe_n_q,
	output reg               separate_serial_out_q,
	output reg               separate_serial_out_oe_n_q,
	// PLL status and lock / data clock pin
	input  wire              pll_locked,
	input  wire              lock_or_rate_clock_pin_in,
	output reg               lock_or_rate_clock_pin_q,
	output reg               lock_or_rate_clock_pin_oe_n_q,
	// Sample data ports
	input  wire              sample_clock,
	input  wire [DATA_W-1:0] first_port_data,
	input  wire              channel_select_line,
	input  wire              second_port_bit_fourteen_in,
	input  wire [DATA_W-3:0] second_port_low,
	output reg               second_port_bit_fourteen_q,
	output reg               second_port_bit_fourteen_oe_n_q,
	// Captured sample pairs
	output reg  [DATA_W-1:0] i_sample_q,
	output reg  [DATA_W-1:0] q_sample_q,
	output reg               sample_valid_q,
	input  wire              sample_ready,
	output reg               sample_overrun_q
);
	localparam NREG = `REG_COUNT;

	// Two-flop synchronisers plus one history flop for edge detection
	reg [1:0]        sclk_s_q;
	reg [1:0]        cs_s_q;
	reg [1:0]        sdi_s_q;
	reg [1:0]        hwrst_s_q;
	reg [1:0]        lock_s_q;
	reg [1:0]        smp_s_q;
	reg              sclk_prev_q;
	reg              smp_prev_q;
	reg [DATA_W-1:0] p1_s1_q;
	reg [DATA_W-1:0] p1_s2_q;
	reg [DATA_W-1:0] p2_s1_q;
	reg [DATA_W-1:0] p2_s2_q;
	reg              sel_s1_q;
	reg              sel_s2_q;

	wire sclk_rise = sclk_s_q[1] && !sclk_prev_q;
	wire sclk_fall = !sclk_s_q[1] && sclk_prev_q;
	wire cs_high   = cs_s_q[1];
	wire hw_reset  = hwrst_s_q[1];
	wire smp_rise  = smp_s_q[1] && !smp_prev_q;

	always @(posedge clk) begin
		if (rst) begin
			sclk_s_q    <= 2'h0;
			cs_s_q      <= 2'h3;
			sdi_s_q     <= 2'h0;
			hwrst_s_q   <= 2'h0;
			lock_s_q    <= 2'h0;
			smp_s_q     <= 2'h0;
			sclk_prev_q <= 1'b0;
			smp_prev_q  <= 1'b0;
			p1_s1_q     <= {DATA_W{1'b0}};
			p1_s2_q     <= {DATA_W{1'b0}};
			p2_s1_q     <= {DATA_W{1'b0}};
			p2_s2_q     <= {DATA_W{1'b0}};
			sel_s1_q    <= 1'b0;
			sel_s2_q    <= 1'b0;
		end else begin
			sclk_s_q    <= {sclk_s_q[0], serial_clock};
			cs_s_q      <= {cs_s_q[0], serial_chip_select};
			sdi_s_q     <= {sdi_s_q[0], sdio_in};
			hwrst_s_q   <= {hwrst_s_q[0], reset_pin};
			lock_s_q    <= {lock_s_q[0], pll_locked};
			smp_s_q     <= {smp_s_q[0], sample_clock};
			sclk_prev_q <= sclk_s_q[1];
			smp_prev_q  <= smp_s_q[1];
			p1_s1_q     <= first_port_data;
			p1_s2_q     <= p1_s1_q;
			p2_s1_q     <= {channel_select_line, second_port_bit_fourteen_in, second_port_low};
			p2_s2_q     <= p2_s1_q;
			sel_s1_q    <= channel_select_line;
			sel_s2_q    <= sel_s1_q;
		end
	end

	// Register file, one byte per entry
	reg  [8*NREG-1:0] regs_q;
	wire [8*NREG-1:0] regs_d;
	reg               soft_reset_q;
	reg               wr_en_q;
	reg  [4:0]        wr_addr_q;
	reg  [7:0]        wr_data_q;
	wire [7:0]        spc = regs_q[8*`SERIAL_PORT_CONFIG_ADDR +: 8];
	wire [7:0]        dcc = regs_q[8*`DATA_CLOCK_CONFIG_ADDR +: 8];
	wire              sdio_output = spc[`SPC_SDIO_OUTPUT_BIT];
	wire              sdo_rate    = spc[`SPC_SDO_RATE_BIT];
	wire              one_port    = dcc[`DCC_ONE_PORT_BIT];
	wire              pll_enable  = dcc[`DCC_PLL_ENABLE_BIT];
	wire              lock_as_clk = dcc[`DCC_LOCK_AS_CLK_BIT];
	wire              clk_is_in   = dcc[`DCC_CLK_INPUT_BIT];

	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : reg_entry
			assign regs_d[8*g +: 8] =
				(rst || hw_reset) ? `REG_RESET_VALUE : // RULE13 RULE9
				(soft_reset_q && g != `SERIAL_PORT_CONFIG_ADDR) ? `REG_RESET_VALUE : // RULE15
				(wr_en_q && wr_addr_q == g) ? wr_data_q : regs_q[8*g +: 8];
		end
	endgenerate

	// One process owns the whole register vector
	always @(posedge clk) begin
		regs_q <= regs_d;
	end

	always @(posedge clk) begin
		if (rst || hw_reset) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= wr_en_q && wr_addr_q == `SERIAL_PORT_CONFIG_ADDR
				&& wr_data_q[`SPC_SOFT_RESET_BIT]; // RULE14
		end
	end

	// Serial engine: 8-bit instruction then one data byte, MSB first
	reg  [4:0] cnt_q;
	reg  [6:0] sh_in_q;
	reg  [7:0] instr_q;
	reg  [7:0] sh_out_q;
	reg        out_bit_q;
	wire [7:0] next_byte = {sh_in_q, sdi_s_q[1]};
	wire [4:0] instr_addr = next_byte[`INSTR_ADDR_MSB:0];
	wire       is_read = instr_q[`INSTR_READ_BIT];
	wire       rd_phase = !cs_high && is_read && cnt_q >= `INSTR_BITS;
	wire [7:0] rd_byte = (instr_addr < NREG) ? regs_q[8*instr_addr +: 8] : 8'h00;

	always @(posedge clk) begin
		if (rst || hw_reset || cs_high) begin
			cnt_q     <= 5'h00; // RULE12
			sh_in_q   <= 7'h00;
			instr_q   <= 8'h00;
			sh_out_q  <= 8'h00;
			out_bit_q <= 1'b0;
			wr_en_q   <= 1'b0;
			wr_addr_q <= 5'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_en_q <= 1'b0;
			if (sclk_rise && cnt_q != `FRAME_BITS) begin
				sh_in_q <= next_byte[6:0]; // RULE10
				cnt_q   <= cnt_q + 5'h01;
				if (cnt_q == `INSTR_BITS - 5'h01) begin
					instr_q  <= next_byte;
					sh_out_q <= rd_byte;
				end
				if (cnt_q == `FRAME_BITS - 5'h01 && !is_read) begin
					wr_en_q   <= 1'b1;
					wr_addr_q <= instr_q[`INSTR_ADDR_MSB:0];
					wr_data_q <= next_byte;
				end
			end
			if (sclk_fall && rd_phase) begin
				out_bit_q <= sh_out_q[7]; // RULE11
				sh_out_q  <= {sh_out_q[6:0], 1'b0};
			end
		end
	end

	// Sample capture and data rate clock
	reg  [DATA_W-1:0] i_hold_q;
	reg               have_i_q;
	reg               push_q;
	reg  [2*DATA_W-1:0] push_data_q;
	reg               rate_clk_q;
	wire              fifo_in_ready;
	wire              fifo_out_valid;
	wire [2*DATA_W-1:0] fifo_out_data;
	wire              fifo_pop = fifo_out_valid && (!sample_valid_q || sample_ready);

	always @(posedge clk) begin
		if (rst) begin
			i_hold_q    <= {DATA_W{1'b0}};
			have_i_q    <= 1'b0;
			push_q      <= 1'b0;
			push_data_q <= {2*DATA_W{1'b0}};
			rate_clk_q  <= 1'b0;
		end else begin
			push_q <= 1'b0;
			if (smp_rise) begin
				if (one_port) begin
					rate_clk_q <= !rate_clk_q;
					if (sel_s2_q) begin
						i_hold_q <= p1_s2_q; // RULE3
						have_i_q <= 1'b1;
					end else begin
						push_q      <= have_i_q; // RULE4 RULE17
						push_data_q <= {i_hold_q, p1_s2_q};
						have_i_q    <= 1'b0;
					end
				end else begin
					rate_clk_q  <= 1'b1;
					push_q      <= 1'b1;
					push_data_q <= {p1_s2_q, p2_s2_q}; // RULE5
				end
			end else if (!one_port && !smp_s_q[1]) begin
				rate_clk_q <= 1'b0;
			end
		end
	end

	sample_fifo #(
		.WIDTH (2*DATA_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push_q),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data_q),
		.out_valid (fifo_out_valid),
		.out_ready (!sample_valid_q || sample_ready),
		.out_data  (fifo_out_data)
	);

	// Output staging and pins
	always @(posedge clk) begin
		if (rst) begin
			i_sample_q       <= {DATA_W{1'b0}};
			q_sample_q       <= {DATA_W{1'b0}};
			sample_valid_q   <= 1'b0;
			sample_overrun_q <= 1'b0;
		end else begin
			if (fifo_pop) begin
				i_sample_q     <= fifo_out_data[2*DATA_W-1:DATA_W];
				q_sample_q     <= fifo_out_data[DATA_W-1:0];
				sample_valid_q <= 1'b1;
			end else if (sample_ready) begin
				sample_valid_q <= 1'b0;
			end
			if (push_q && !fifo_in_ready) begin
				sample_overrun_q <= 1'b1;
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			sdio_out_q                      <= 1'b0;
			sdio_oe_n_q                     <= 1'b1;
			separate_serial_out_q           <= 1'b0;
			separate_serial_out_oe_n_q      <= 1'b1;
			lock_or_rate_clock_pin_q        <= 1'b0;
			lock_or_rate_clock_pin_oe_n_q   <= 1'b1;
			second_port_bit_fourteen_q      <= 1'b0;
			second_port_bit_fourteen_oe_n_q <= 1'b1;
		end else begin
			sdio_out_q  <= out_bit_q;
			sdio_oe_n_q <= !(rd_phase && sdio_output); // RULE9
			if (sdo_rate) begin
				separate_serial_out_q      <= rate_clk_q; // RULE8
				separate_serial_out_oe_n_q <= rd_phase && sdio_output; // RULE7
			end else begin
				separate_serial_out_q      <= out_bit_q; // RULE7
				separate_serial_out_oe_n_q <= !(rd_phase && !sdio_output);
			end
			if (lock_as_clk) begin
				lock_or_rate_clock_pin_q      <= rate_clk_q; // RULE2
				lock_or_rate_clock_pin_oe_n_q <= clk_is_in;
			end else begin
				lock_or_rate_clock_pin_q      <= pll_enable && lock_s_q[1]; // RULE1
				lock_or_rate_clock_pin_oe_n_q <= !pll_enable;
			end
			if (one_port && !pll_enable) begin
				second_port_bit_fourteen_q      <= smp_s_q[1]; // RULE6
				second_port_bit_fourteen_oe_n_q <= 1'b0;
			end else begin
				second_port_bit_fourteen_q      <= 1'b0;
				second_port_bit_fourteen_oe_n_q <= 1'b1;
			end
		end
	end
endmodule // dac_port

/* verification/dac_port_asserts.sv */
// Concurrent checks on the DAC digital port outputs
`timescale 1ns/1ps
module dac_port_asserts #(
	parameter DATA_W = 16
) (
	// Clock and reset
	input wire              clk,
	input wire              rst,
	// Serial port
	input wire              serial_clock,
	input wire              serial_chip_select,
	input wire              sdio_out_q,
	input wire              sdio_oe_n_q,
	input wire              separate_serial_out_oe_n_q,
	// Sample path
	input wire              sample_clock,
	input wire              second_port_bit_fourteen_q,
	input wire              second_port_bit_fourteen_oe_n_q,
	input wire [DATA_W-1:0] i_sample_q,
	input wire [DATA_W-1:0] q_sample_q,
	input wire              sample_valid_q,
	input wire              sample_ready,
	input wire              sample_overrun_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_pins_released: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> sdio_oe_n_q && separate_serial_out_oe_n_q && second_port_bit_fourteen_oe_n_q)
		else $error("pin driven after reset");
	a_reset_empty: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> !sample_valid_q && !sample_overrun_q)
		else $error("sample path not empty after reset");
	a_one_out_line: assert property (!sdio_oe_n_q |-> separate_serial_out_oe_n_q)
		else $error("both serial out lines driven");
	a_pair_holds: assert property (sample_valid_q && !sample_ready |=>
		sample_valid_q && $stable(i_sample_q) && $stable(q_sample_q))
		else $error("sample pair changed while stalled");
	a_overrun_sticky: assert property (sample_overrun_q |=> sample_overrun_q)
		else $error("overrun flag cleared");
	a_cs_releases: assert property ($rose(serial_chip_select) |-> ##[1:6] sdio_oe_n_q)
		else $error("data line still driven after deselect");
	a_double_clock: assert property ($rose(sample_clock) && !second_port_bit_fourteen_oe_n_q
		|-> ##[1:4] second_port_bit_fourteen_q)
		else $error("doubled rate clock missing");
	// A read bit may only move a few cycles after the serial clock went low
	a_launch_falling: assert property (!sdio_oe_n_q && !$past(sdio_oe_n_q)
		&& $changed(sdio_out_q) |-> !$past(serial_clock, 3))
		else $error("read bit launched off the falling edge");
	c_sdio_read: cover property ($fell(sdio_oe_n_q));
	c_overrun: cover property ($rose(sample_overrun_q));
	c_pop: cover property (sample_valid_q && sample_ready);
endmodule // dac_port_asserts

bind dac_port dac_port_asserts #(.DATA_W(DATA_W)) chk_u (
	.clk, .rst, .serial_clock, .serial_chip_select, .sdio_out_q, .sdio_oe_n_q,
	.separate_serial_out_oe_n_q, .sample_clock, .second_port_bit_fourteen_q,
	.second_port_bit_fourteen_oe_n_q, .i_sample_q, .q_sample_q, .sample_valid_q,
	.sample_ready, .sample_overrun_q
);

/* verification/far_end.sv */
// Host controller and sample source model
`timescale 1ns/1ps
module far_end (
	// Clock
	input wire        clk,
	// Serial port
	output reg        serial_clock,
	output reg        serial_chip_select,
	output reg        host_data,
	input wire        line_out,
	// Sample source
	output reg        sample_clock,
	output reg [15:0] p1,
	output reg [15:0] p2
);
	initial begin
		serial_clock = 1'b0;
		serial_chip_select = 1'b1;
		host_data = 1'b0;
		sample_clock = 1'b0;
		p1 = 16'h0000;
		p2 = 16'h0000;
	end
	// Sends n bits of w MSB first; fewer than 16 aborts the frame
	task xfer(input [15:0] w, input integer n, output [7:0] r);
		integer i;
		begin
			r = 8'h00;
			serial_chip_select <= 1'b0;
			for (i = 15; i >= 16 - n; i = i - 1) begin
				host_data <= w[i];
				repeat (4) @(posedge clk);
				serial_clock <= 1'b1;
				repeat (4) @(posedge clk);
				// Read bit is sampled late in the high phase to clear the sync delay
				if (i < 8) r[i] = line_out;
				serial_clock <= 1'b0;
			end
			repeat (4) @(posedge clk);
			serial_chip_select <= 1'b1;
			host_data <= ~host_data;
			repeat (8) @(posedge clk);
		end
	endtask
	// One sample: b[15] is the select line in one-port mode
	task sample(input [15:0] a, input [15:0] b);
		begin
			p1 <= a;
			p2 <= b;
			repeat (4) @(posedge clk);
			sample_clock <= 1'b1;
			repeat (4) @(posedge clk);
			sample_clock <= 1'b0;
			repeat (2) @(posedge clk);
			p1 <= ~a;
			p2 <= ~b;
			repeat (2) @(posedge clk);
		end
	endtask
endmodule // far_end

/* verification/dac_port_tb.sv */
// Self-checking bench for the DAC digital port
`timescale 1ns/1ps
module dac_port_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg reset_pin = 1'b0;
	reg pll_locked = 1'b0;
	reg sample_ready = 1'b0;
	reg [7:0] r;
	integer err_count = 0;
	integer total_checks = 0;
	integer cyc = 0;
	wire serial_clock, serial_chip_select, hd, sample_clock;
	wire [15:0] p1, p2, i_sample_q, q_sample_q;
	wire sdio_out_q, sdio_oe_n_q, separate_serial_out_q, separate_serial_out_oe_n_q;
	wire lock_q, lock_oe_n, b14_q, b14_oe_n, sample_valid_q, sample_overrun_q;
	// A released out line shows the inverse of its last level
	wire line_out = !sdio_oe_n_q ? sdio_out_q :
		!separate_serial_out_oe_n_q ? separate_serial_out_q : ~separate_serial_out_q;
	always #50 clk = ~clk;
	dac_port dut_u (
		.clk, .rst, .reset_pin, .serial_clock, .serial_chip_select,
		.sdio_in(sdio_oe_n_q ? hd : sdio_out_q), .sdio_out_q, .sdio_oe_n_q,
		.separate_serial_out_q, .separate_serial_out_oe_n_q, .pll_locked,
		.lock_or_rate_clock_pin_in(lock_oe_n ? ~lock_q : lock_q),
		.lock_or_rate_clock_pin_q(lock_q), .lock_or_rate_clock_pin_oe_n_q(lock_oe_n),
		.sample_clock, .first_port_data(p1), .channel_select_line(p2[15]),
		.second_port_bit_fourteen_in(b14_oe_n ? p2[14] : b14_q),
		.second_port_low(p2[13:0]), .second_port_bit_fourteen_q(b14_q),
		.second_port_bit_fourteen_oe_n_q(b14_oe_n), .i_sample_q, .q_sample_q,
		.sample_valid_q, .sample_ready, .sample_overrun_q
	);
	far_end host_u (
		.clk, .serial_clock, .serial_chip_select, .host_data(hd), .line_out,
		.sample_clock, .p1, .p2
	);
	task chk(input [15:0] got, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [4:0] a, input [7:0] d);
		host_u.xfer({3'h0, a, d}, 16, r);
	endtask
	task rd(input [4:0] a, input [7:0] e);
		begin
			host_u.xfer({3'h4, a, 8'h00}, 16, r);
			chk({8'h00, r}, {8'h00, e});
		end
	endtask
	task pop(input [15:0] ei, input [15:0] eq);
		integer k;
		begin
			k = 0;
			@(negedge clk);
			while (sample_valid_q !== 1'b1 && k < 40) begin
				@(negedge clk);
				k = k + 1;
			end
			chk({15'h0000, sample_valid_q}, 16'h0001);
			chk(i_sample_q, ei);
			chk(q_sample_q, eq);
			@(posedge clk) sample_ready <= 1'b1;
			@(posedge clk) sample_ready <= 1'b0;
		end
	endtask
	task t_regs;
		begin
			rd(5'h00, 8'h00);
			rd(5'h02, 8'h00);
			wr(5'h10, 8'hFF);
			rd(5'h10, 8'h00);
			wr(5'h02, 8'h01);
			host_u.xfer(16'h0203, 12, r);
			rd(5'h02, 8'h01);
			$display("registers done");
		end
	endtask
	task t_samples;
		begin
			@(negedge clk);
			chk({15'h0000, b14_oe_n}, 16'h0000);
			host_u.sample(16'hA5C3, 16'h8000);
			host_u.sample(16'h3C5A, 16'h0000);
			pop(16'hA5C3, 16'h3C5A);
			wr(5'h02, 8'h00);
			host_u.sample(16'h1357, 16'hC0DE);
			pop(16'h1357, 16'hC0DE);
			$display("samples done");
		end
	endtask
	task t_fifo;
		reg [15:0] k;
		begin
			for (k = 0; k < 6; k = k + 1)
				host_u.sample(16'h1000 + k, 16'h2000 + k);
			@(negedge clk);
			chk({15'h0000, sample_overrun_q}, 16'h0001);
			for (k = 0; k < 4; k = k + 1)
				pop(16'h1000 + k, 16'h2000 + k);
			@(posedge clk) sample_ready <= 1'b1;
			repeat (4) @(posedge clk);
			sample_ready <= 1'b0;
			@(negedge clk);
			chk({15'h0000, sample_valid_q}, 16'h0000);
			$display("fifo done");
		end
	endtask
	task t_rate;
		begin
			wr(5'h00, 8'h40);
			wr(5'h02, 8'h09);
			host_u.sample(16'h1111, 16'h8000);
			@(negedge clk);
			chk({14'h0000, separate_serial_out_oe_n_q, separate_serial_out_q}, 16'h0001);
			chk({14'h0000, lock_oe_n, lock_q}, 16'h0001);
			host_u.sample(16'h2222, 16'h0000);
			@(negedge clk);
			chk({14'h0000, separate_serial_out_oe_n_q, separate_serial_out_q}, 16'h0000);
			chk({14'h0000, lock_oe_n, lock_q}, 16'h0000);
			pop(16'h1111, 16'h2222);
			wr(5'h02, 8'h0D);
			@(negedge clk);
			chk({15'h0000, lock_oe_n}, 16'h0001);
			$display("rate clock done");
		end
	endtask
	task t_lock;
		begin
			wr(5'h02, 8'h02);
			repeat (8) @(negedge clk);
			chk({14'h0000, lock_oe_n, lock_q}, 16'h0000);
			@(posedge clk) pll_locked <= 1'b1;
			repeat (8) @(negedge clk);
			chk({14'h0000, lock_oe_n, lock_q}, 16'h0001);
			$display("lock done");
		end
	endtask
	task t_resets;
		begin
			wr(5'h00, 8'h80);
			rd(5'h00, 8'h80);
			wr(5'h02, 8'h01);
			wr(5'h00, 8'hA0);
			rd(5'h02, 8'h00);
			rd(5'h00, 8'hA0);
			wr(5'h02, 8'h01);
			@(posedge clk) reset_pin <= 1'b1;
			repeat (6) @(posedge clk);
			reset_pin <= 1'b0;
			repeat (4) @(posedge clk);
			rd(5'h00, 8'h00);
			rd(5'h02, 8'h00);
			$display("resets done");
		end
	endtask
	task wrap_up;
		begin
			$display("checks=%0d errors=%0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_regs;
		t_samples;
		t_fifo;
		t_rate;
		t_lock;
		t_resets;
		wrap_up;
	end
endmodule // dac_port_tb
